// *** hdl/spi_port_map.vh ***
// Register map, field positions and reset values of the serial port.
// Included by the port module; holds definitions only.
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH

// Byte addresses on the register bus
`define ADDR_STATUS 12'h000
`define ADDR_CONTROL 12'h004
`define ADDR_BUFFER 12'h008
`define ADDR_IRQ 12'h00C

// port_status fields
`define ST_RX_FULL 0
`define ST_TX_FULL 1
`define ST_RX_OVF 6
`define ST_STOP_IDLE 13
`define ST_ENABLE 15

// port_control fields
`define CT_PRIM_LO 0
`define CT_SEC_LO 2
`define CT_MASTER 5
`define CT_CLK_IDLE 6
`define CT_SEL_EN 7
`define CT_WIDE 10
`define CT_OUT_OFF 11
`define CT_FS_DIR 13
`define CT_FRAMED 14
`define CT_WR_MASK 16'h6FFF

// Interrupt register fields
`define IQ_FLAG 0
`define IQ_ENABLE 1
`define IQ_PRIO_LO 2

// Reset values
`define RST_STATUS 16'h0000
`define RST_CONTROL 16'h0000
`define RST_BUFFER 16'h0000
`define RST_IRQ 16'h0000

`endif

// *** hdl/spi_power_mode_and_regs.v ***
// Serial peripheral port with APB registers and power-save behaviour.
// Assumes pins and power-mode requests are synchronous to mclk; slave
// serial clock is oversampled by mclk, so it must stay well below mclk/4.
// What this block does
// - Master role in Sleep: baud generator halts and returns to reset
// - Master role in Sleep: running transfer aborts, shifter stops both ways
// - After wake the aborted master word is dropped, never resumed
// - Slave role keeps working in Sleep on the external serial clock
// - Slave transfer underway at Sleep entry runs to completion
// - Slave completion in Sleep sets receive-full and interrupt flag
// - Interrupt flag with enable set wakes the device
// - Wake from Sleep goes to vector if priority above CPU, else continues
// - Sleep entry never resets slave-role logic
// - All register contents survive Sleep entry and exit
// - Stop-in-idle status bit 13 chooses halt or run in Idle
// - Stop-in-idle set: Idle halts the master role exactly like Sleep
// - Stop-in-idle clear, the default: port runs normally in Idle
// - Select enable bit 7: select pin low gates slave transfers
// - Framed modes: select pin is frame sync, direction from bit 13
// - One buffer address: write loads transmit, read returns receive, reset zero
// - Unimplemented status and control bits read zero; both reset zero
// - Frame sync pulse is active high, one serial clock long
// - Master serial clock is mclk through primary then secondary prescaler
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.vh"

module spi_power_mode_and_regs
(
    input wire mclk,              // System clock
    input wire sys_rst,           // Synchronous reset, active high
    input wire psel,              // APB select
    input wire penable,           // APB enable
    input wire pwrite,            // APB direction
    input wire [11:0] paddr,      // APB byte address
    input wire [31:0] pwdata,     // APB write data
    output reg [31:0] prdata,     // APB read data
    output reg pready,            // APB ready
    output reg pslverr,           // APB error on unmapped address
    input wire sleep_mode,        // Device is in Sleep
    input wire idle_mode,         // Device is in Idle
    input wire [2:0] cpu_priority, // Current CPU priority
    input wire sck_in,            // Serial clock pin, input side
    output reg sck_out,           // Serial clock pin, output side
    output reg sck_oe_n,          // Serial clock drive enable, low drives
    input wire sdi,               // Serial data in
    output reg sdo,               // Serial data out
    output reg sdo_oe_n,          // Serial data out drive enable, low drives
    input wire ss_in,             // Select pin, input side
    output reg ss_out,            // Select pin, output side
    output reg ss_oe_n,           // Select pin drive enable, low drives
    output reg xfer_irq_flag,     // Transfer interrupt flag
    output reg wake_req,          // Wake request to power control
    output reg vector_take,       // Pulse: enter port interrupt vector
    output reg resume_next        // Pulse: continue after power-save instruction
);

reg [15:0] ctrl;
reg port_enable;
reg stop_in_idle;
reg rx_overflow;
reg rx_buffer_full;
reg tx_buffer_full;
reg xfer_irq_enable;
reg [2:0] irq_prio;
reg [15:0] tx_holding_reg;
reg [15:0] rx_holding_reg;
reg [15:0] sr;
reg [4:0] bit_cnt;
reg busy;
reg start_pend;
reg fs_on;
reg fs_seen;
reg samp_bit;
reg sck_lvl;
reg sck_prev;
reg [9:0] brg_cnt;
reg [15:0] rdata;

wire master_enable = ctrl[`CT_MASTER];
wire clk_idle = ctrl[`CT_CLK_IDLE];
wire wide_word = ctrl[`CT_WIDE];
wire framed_enable = ctrl[`CT_FRAMED];
wire frame_sync_direction = ctrl[`CT_FS_DIR];
wire select_pin_enable = ctrl[`CT_SEL_EN];
wire [1:0] primary_prescale = ctrl[`CT_PRIM_LO +: 2];
wire [2:0] secondary_prescale = ctrl[`CT_SEC_LO +: 3];

wire halted = sleep_mode | (idle_mode & stop_in_idle);
wire stop_master = master_enable & halted;
wire active = port_enable & ~stop_master;

wire [6:0] prim = (primary_prescale == 2'd3) ? 7'd1 :
                  (primary_prescale == 2'd2) ? 7'd4 :
                  (primary_prescale == 2'd1) ? 7'd16 : 7'd64;
wire [3:0] sec = 4'd8 - {1'b0, secondary_prescale};
wire [10:0] div_full = prim * sec;
wire [9:0] div_m1 = div_full[9:0] - 10'd1;
wire m_run = busy | framed_enable;
wire tick = active & master_enable & m_run & (brg_cnt == div_m1);

wire s_lead = (sck_prev == clk_idle) & (sck_in != clk_idle);
wire s_trail = (sck_prev != clk_idle) & (sck_in == clk_idle);
wire lead = master_enable ? (tick & (sck_lvl == clk_idle)) : (port_enable & s_lead);
wire trail = master_enable ? (tick & (sck_lvl != clk_idle)) : (port_enable & s_trail);

wire sel_ok = framed_enable | ~select_pin_enable | ~ss_in;
wire [4:0] n_bits = wide_word ? 5'd16 : 5'd8;
wire [15:0] rx_word = {sr[14:0], samp_bit};
wire done = trail & busy & (bit_cnt == n_bits);
wire frame_master = framed_enable & ~frame_sync_direction;

wire setup = psel & ~penable & ~pready;
wire access = psel & penable & pready;
wire wr = access & pwrite;
wire rd = access & ~pwrite;
wire wr_status = wr & (paddr == `ADDR_STATUS);
wire wr_ctrl = wr & (paddr == `ADDR_CONTROL);
wire wr_buf = wr & (paddr == `ADDR_BUFFER);
wire wr_irq = wr & (paddr == `ADDR_IRQ);
wire rd_buf = rd & (paddr == `ADDR_BUFFER);
wire mapped = (paddr == `ADDR_STATUS) | (paddr == `ADDR_CONTROL) |
              (paddr == `ADDR_BUFFER) | (paddr == `ADDR_IRQ);
wire wake_now = xfer_irq_flag & xfer_irq_enable;

// Read mux; unimplemented bits stay zero
always @*
begin
    rdata = 16'h0000;
    if (paddr == `ADDR_STATUS)
    begin
        rdata[`ST_ENABLE] = port_enable;
        rdata[`ST_STOP_IDLE] = stop_in_idle;
        rdata[`ST_RX_OVF] = rx_overflow;
        rdata[`ST_TX_FULL] = tx_buffer_full;
        rdata[`ST_RX_FULL] = rx_buffer_full;
    end
    else if (paddr == `ADDR_CONTROL)
    begin
        rdata = ctrl;
    end
    else if (paddr == `ADDR_BUFFER)
    begin
        rdata = rx_holding_reg;
    end
    else if (paddr == `ADDR_IRQ)
    begin
        rdata[`IQ_FLAG] = xfer_irq_flag;
        rdata[`IQ_ENABLE] = xfer_irq_enable;
        rdata[`IQ_PRIO_LO +: 3] = irq_prio;
    end
end

// Bus slave: answer is registered, so pready rises in the first access cycle
always @(posedge mclk)
begin
    if (sys_rst)
    begin
        pready <= 1'b0;
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= setup;
        if (setup)
        begin
            prdata <= {16'h0000, rdata};
            pslverr <= ~mapped;
        end
    end
end

// Register file; registers are never touched by power modes
// contents kept in sleep
always @(posedge mclk)
begin
    if (sys_rst)
    begin
        ctrl <= `RST_CONTROL;
        port_enable <= 1'b0;
        stop_in_idle <= 1'b0;
        xfer_irq_enable <= 1'b0;
        irq_prio <= 3'h0;
        tx_holding_reg <= `RST_BUFFER;
    end
    else
    begin
        if (wr_ctrl)
            ctrl <= pwdata[15:0] & `CT_WR_MASK;
        if (wr_status)
        begin
            port_enable <= pwdata[`ST_ENABLE];
            stop_in_idle <= pwdata[`ST_STOP_IDLE];
        end
        if (wr_irq)
        begin
            xfer_irq_enable <= pwdata[`IQ_ENABLE];
            irq_prio <= pwdata[`IQ_PRIO_LO +: 3];
        end
        if (wr_buf)
            tx_holding_reg <= pwdata[15:0];
    end
end

// Baud generator and master clock level
always @(posedge mclk)
begin
    if (sys_rst | ~active | ~master_enable | ~m_run)
    begin
        brg_cnt <= 10'h000;
        sck_lvl <= clk_idle;
    end
    else if (brg_cnt == div_m1)
    begin
        brg_cnt <= 10'h000;
        sck_lvl <= ~sck_lvl;
    end
    else
        brg_cnt <= brg_cnt + 10'd1;
end

// Shift engine, framing and status flags
always @(posedge mclk)
begin
    if (sys_rst)
    begin
        sr <= 16'h0000;
        bit_cnt <= 5'd0;
        busy <= 1'b0;
        start_pend <= 1'b0;
        fs_on <= 1'b0;
        fs_seen <= 1'b0;
        samp_bit <= 1'b0;
        sck_prev <= 1'b0;
        ss_out <= 1'b0;
        rx_holding_reg <= `RST_BUFFER;
        rx_buffer_full <= 1'b0;
        tx_buffer_full <= 1'b0;
        rx_overflow <= 1'b0;
        xfer_irq_flag <= 1'b0;
    end
    else
    begin
        sck_prev <= sck_in;
        if (wr_buf)
        begin
            tx_buffer_full <= 1'b1;
            start_pend <= 1'b1;
        end
        // Clears first, so a completion in the same cycle wins below
        if (rd_buf)
            rx_buffer_full <= 1'b0;
        if (wr_status & ~pwdata[`ST_RX_OVF])
            rx_overflow <= 1'b0;
        if (wr_irq & ~pwdata[`IQ_FLAG])
            xfer_irq_flag <= 1'b0;

        if (~active)
        begin
            busy <= 1'b0;
            bit_cnt <= 5'd0;
            start_pend <= 1'b0;
            fs_on <= 1'b0;
            fs_seen <= 1'b0;
            ss_out <= 1'b0;
        end
        else if (~master_enable & ~sel_ok)
        begin
            busy <= 1'b0;
            bit_cnt <= 5'd0;
        end
        else
        begin
            if (lead & (busy | ~master_enable & ~framed_enable))
            begin
                samp_bit <= sdi;
                busy <= 1'b1;
                bit_cnt <= bit_cnt + 5'd1;
            end
            if (trail & busy & (bit_cnt != 5'd0))
                sr <= rx_word;
            if (done)
            begin
                busy <= 1'b0;
                bit_cnt <= 5'd0;
                if (rx_buffer_full)
                    rx_overflow <= 1'b1;
                else
                    rx_holding_reg <= wide_word ? rx_word : {8'h00, rx_word[7:0]};
                rx_buffer_full <= 1'b1;
                xfer_irq_flag <= 1'b1;
            end
            // Non-framed master starts on the written word only
            if (master_enable & ~framed_enable & start_pend & ~busy & ~wr_buf)
            begin
                sr <= tx_holding_reg;
                tx_buffer_full <= 1'b0;
                start_pend <= 1'b0;
                busy <= 1'b1;
            end
            // Non-framed slave preloads the word before the first edge
            if (~master_enable & ~framed_enable & tx_buffer_full & ~busy & ~wr_buf)
            begin
                sr <= tx_holding_reg;
                tx_buffer_full <= 1'b0;
                start_pend <= 1'b0;
            end
            if (frame_master & trail)
            begin
                if (fs_on)
                begin
                    ss_out <= 1'b0;
                    fs_on <= 1'b0;
                    sr <= tx_holding_reg;
                    tx_buffer_full <= wr_buf;
                    busy <= 1'b1;
                    bit_cnt <= 5'd0;
                end
                else if (start_pend & (~busy | done) & ~wr_buf)
                begin
                    ss_out <= 1'b1;
                    fs_on <= 1'b1;
                    start_pend <= 1'b0;
                end
            end
            if (framed_enable & frame_sync_direction)
            begin
                if (lead & ss_in & ~busy)
                    fs_seen <= 1'b1;
                // A received pulse starts even if no new word was written
                if (trail & fs_seen)
                begin
                    fs_seen <= 1'b0;
                    sr <= tx_holding_reg;
                    tx_buffer_full <= wr_buf;
                    start_pend <= 1'b0;
                    busy <= 1'b1;
                    bit_cnt <= 5'd0;
                end
            end
        end
    end
end

// Pin drivers and wake logic, all registered
always @(posedge mclk)
begin
    if (sys_rst)
    begin
        sck_out <= 1'b0;
        sck_oe_n <= 1'b1;
        sdo <= 1'b0;
        sdo_oe_n <= 1'b1;
        ss_oe_n <= 1'b1;
        wake_req <= 1'b0;
        vector_take <= 1'b0;
        resume_next <= 1'b0;
    end
    else
    begin
        sck_out <= master_enable ? sck_lvl : clk_idle;
        sck_oe_n <= ~(port_enable & master_enable);
        sdo <= wide_word ? sr[15] : sr[7];
        sdo_oe_n <= ~(port_enable & ~ctrl[`CT_OUT_OFF]);
        ss_oe_n <= ~(port_enable & frame_master);
        wake_req <= wake_now;
        vector_take <= wake_now & ~wake_req & sleep_mode & (irq_prio > cpu_priority);
        resume_next <= wake_now & ~wake_req & sleep_mode & ~(irq_prio > cpu_priority);
    end
end

endmodule // spi_power_mode_and_regs
`default_nettype wire

// *** bench/spi_chk.sv ***
// Checker for the serial port: sleep halt, wake paths, register read zeros.
// Bound to the port module; watches its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.vh"
module spi_chk
(
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic sleep_mode, // Sleep
    input wire logic sck_out, // Serial clock
    input wire logic sck_oe_n, // Low drives clock
    input wire logic xfer_irq_flag, // Transfer flag
    input wire logic wake_req, // Wake request
    input wire logic vector_take, // Vector pulse
    input wire logic resume_next // Resume pulse
);
    logic msleep;
    assign msleep = sleep_mode && !sck_oe_n;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    sck_halt_a:
        assert property (msleep [*4] |-> $stable(sck_out)) else $error("sck runs in sleep");
    abort_flag_a:
        assert property (msleep [*4] |-> !$rose(xfer_irq_flag)) else $error("flag on abort");
    wake_cause_a:
        assert property ($rose(wake_req) |-> xfer_irq_flag) else $error("wake without flag");
    wake_path_a:
        assert property ($rose(wake_req) && sleep_mode |-> ##[0:2] (vector_take || resume_next))
            else $error("no wake path pulse");
    path_excl_a:
        assert property (vector_take |-> !resume_next ##1 !vector_take) else $error("bad vector");
    flag_hold_a:
        assert property ($fell(xfer_irq_flag) |->
            $past(psel && penable && pwrite && paddr == `ADDR_IRQ) || $past(sys_rst))
            else $error("flag lost");
    ctl_zero_a:
        assert property (pready && !pwrite && paddr == `ADDR_CONTROL |->
            (prdata & 32'hFFFF9000) == 32'h0) else $error("control spare bits set");
    stat_zero_a:
        assert property (pready && !pwrite && paddr == `ADDR_STATUS |->
            (prdata & 32'hFFFF5FBC) == 32'h0) else $error("status spare bits set");
endmodule // spi_chk
bind spi_power_mode_and_regs spi_chk spi_chk_inst (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .sleep_mode(sleep_mode), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .xfer_irq_flag(xfer_irq_flag), .wake_req(wake_req), .vector_take(vector_take),
    .resume_next(resume_next));
`default_nettype wire

// *** bench/spi_peer.sv ***
// Serial peripheral answering the port while the port is master.
// Clock polarity 0: samples on the rising serial edge, shifts on the falling.
`timescale 1ns/1ps
`default_nettype none
module spi_peer
(
    input wire logic sck, // Serial clock line
    input wire logic mosi, // Data from the port
    input wire logic load, // Pulse: take reply
    input wire logic [7:0] reply, // Word sent back
    output logic miso, // Data to the port
    output logic [7:0] got // Word received
);
    logic [7:0] sh = 8'h00;
    assign miso = sh[7];
    always @(posedge sck)
        got <= {got[6:0], mosi};
    // Fill keeps changing so a stale bit cannot pass
    always @(negedge sck or posedge load)
    begin
        if (load)
            sh <= reply;
        else
            sh <= {sh[6:0], ~sh[0]};
    end
endmodule // spi_peer
`default_nettype wire

// *** bench/testbench.sv ***
// Bench for the serial port: registers, master and slave traffic, power modes.
// Assumes the port module, its map header, the checker and the peer model.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.vh"
module testbench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    logic sleep_mode = 1'b0, idle_mode = 1'b0, sck_b = 1'b0, sdi_b = 1'b0, ss_b = 1'b1;
    logic pload = 1'b0;
    logic [2:0] cpu_priority = 3'h0, pr, cp;
    logic [7:0] reply = 8'h00, w;
    logic [15:0] h;
    int err_count = 0, n_tests = 0, cyc = 0, nv = 0, nr = 0, ab, v0, r0, n;
    int seed = 32'h62009FE1;
    wire [31:0] prdata;
    wire [7:0] got;
    wire pready, pslverr, sck_out, sck_oe_n, sdo, sdo_oe_n, ss_out, ss_oe_n, miso;
    wire xfer_irq_flag, wake_req, vector_take, resume_next;
    wire sck_ln = sck_oe_n ? sck_b : sck_out;
    wire sdi_ln = sck_oe_n ? sdi_b : miso;
    wire ss_ln = ss_oe_n ? ss_b : ss_out;
    spi_power_mode_and_regs spi_power_mode_and_regs_inst (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
        .idle_mode(idle_mode), .cpu_priority(cpu_priority), .sck_in(sck_ln),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdi(sdi_ln), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .ss_in(ss_ln), .ss_out(ss_out), .ss_oe_n(ss_oe_n), .xfer_irq_flag(xfer_irq_flag),
        .wake_req(wake_req), .vector_take(vector_take), .resume_next(resume_next));
    spi_peer spi_peer_inst (.sck(sck_ln), .mosi(sdo), .load(pload), .reply(reply),
        .miso(miso), .got(got));
    always #2 mclk = ~mclk;
    task automatic report_and_stop;
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        nv <= nv + (vector_take === 1'b1);
        nr <= nr + (resume_next === 1'b1);
        if (cyc == 60000)
        begin
            err_count++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e)
        begin
            err_count++;
            $display("wrong value at %0t: %h expected %h", $time, a, e);
        end
    endtask
    task automatic apb(input logic wr_n, input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr_n;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        q = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 16'h0000);
        chk(q, e);
    endtask
    task automatic wait_flag;
        for (int i = 0; i < 400 && xfer_irq_flag !== 1'b1; i++)
            @(posedge mclk);
    endtask
    function automatic logic [31:0] path_exp(input logic on, input logic v);
        return {31'h0, on && ((pr > cp) == v)};
    endfunction
    // Serial half period in mclk cycles from the two prescaler codes
    function automatic int half_per(input logic [1:0] pc, input logic [2:0] sc);
        return ((pc == 2'd3) ? 1 : (pc == 2'd2) ? 4 : (pc == 2'd1) ? 16 : 64) * (8 - sc);
    endfunction
    // Bench plays the external master; select low gates the slave
    task automatic slv(input logic sel);
        ss_b <= !sel;
        for (int i = 7; i >= 0; i--)
        begin
            sdi_b <= w[i];
            if (i == 3)
                sleep_mode <= sel;
            repeat (5) @(posedge mclk);
            sck_b <= 1'b1;
            repeat (5) @(posedge mclk);
            sck_b <= 1'b0;
        end
        sdi_b <= ~w[0];
        repeat (5) @(posedge mclk);
        ss_b <= 1'b1;
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 16; a += 4)
            rdc(a[11:0], 32'h0);
        apb(1'b1, `ADDR_CONTROL, 16'hFFFF);
        rdc(`ADDR_CONTROL, 32'h6FFF);
        apb(1'b1, `ADDR_CONTROL, 16'h0000);
        apb(1'b1, `ADDR_STATUS, 16'hFFBF);
        rdc(`ADDR_STATUS, 32'hA000);
        rdc(12'h010, 32'h0);
        chk({31'h0, lerr}, 32'h1);
        // Three plain master words, then sleep, idle-stop and idle-run mid word
        for (int k = 0; k < 6; k++)
        begin
            ab = (k > 2) ? k - 3 : 3;
            w = 8'($random(seed));
            reply <= 8'($random(seed));
            pload <= 1'b1;
            apb(1'b1, `ADDR_CONTROL, (ab == 3) ? 16'h003B : 16'h003E);
            pload <= 1'b0;
            apb(1'b1, `ADDR_STATUS, (ab == 1) ? 16'hA000 : 16'h8000);
            apb(1'b1, `ADDR_BUFFER, {8'h00, w});
            if (ab < 3)
            begin
                repeat (60) @(posedge mclk);
                sleep_mode <= (ab == 0);
                idle_mode <= (ab != 0);
                repeat (300) @(posedge mclk);
                chk({31'h0, sck_out}, 32'h0);
                chk({31'h0, xfer_irq_flag}, {31'h0, ab == 2});
                sleep_mode <= 1'b0;
                idle_mode <= 1'b0;
            end
            wait_flag;
            chk({31'h0, xfer_irq_flag}, {31'h0, ab > 1});
            if (ab > 1)
            begin
                rdc(`ADDR_BUFFER, {24'h0, reply});
                chk({24'h0, got}, {24'h0, w});
                chk({30'h0, sck_oe_n, sdo_oe_n}, 32'h0);
            end
            apb(1'b1, `ADDR_IRQ, 16'h0000);
        end
        // One 16-bit master word; the peer sees its low byte last
        h = 16'($random(seed));
        reply <= 8'($random(seed));
        pload <= 1'b1;
        apb(1'b1, `ADDR_CONTROL, 16'h043B);
        pload <= 1'b0;
        apb(1'b1, `ADDR_BUFFER, h);
        wait_flag;
        apb(1'b0, `ADDR_BUFFER, 16'h0000);
        chk({24'h0, q[15:8]}, {24'h0, reply});
        chk({24'h0, got}, {24'h0, h[7:0]});
        apb(1'b1, `ADDR_IRQ, 16'h0000);
        apb(1'b1, `ADDR_CONTROL, 16'h0080);
        for (int p = 0; p < 3; p++)
        begin
            w = 8'($random(seed));
            cp = (p == 1) ? 3'h2 : 3'h4;
            pr = (p == 1) ? 3'h5 : 3'h1;
            cpu_priority <= cp;
            apb(1'b1, `ADDR_IRQ, {11'h0, pr, 2'b10});
            v0 = nv;
            r0 = nr;
            slv(p != 0);
            repeat (20) @(posedge mclk);
            chk({31'h0, xfer_irq_flag}, {31'h0, p != 0});
            chk({31'h0, wake_req}, {31'h0, p != 0});
            chk(nv - v0, path_exp(p != 0, 1'b1));
            chk(nr - r0, path_exp(p != 0, 1'b0));
            sleep_mode <= 1'b0;
            rdc(`ADDR_CONTROL, 32'h0080);
            rdc(`ADDR_STATUS, (p != 0) ? 32'h8001 : 32'h8000);
            if (p != 0)
                rdc(`ADDR_BUFFER, {24'h0, w});
            apb(1'b1, `ADDR_IRQ, 16'h0000);
        end
        // Frame master: one sync pulse of one serial clock, then the word
        apb(1'b1, `ADDR_CONTROL, 16'h403E);
        apb(1'b1, `ADDR_BUFFER, {8'h00, w});
        for (int i = 0; i < 200 && ss_out !== 1'b1; i++)
            @(posedge mclk);
        n = 0;
        while (ss_out === 1'b1 && n < 200)
        begin
            n++;
            @(posedge mclk);
        end
        chk(n, 2 * half_per(2'd2, 3'd7));
        chk({31'h0, ss_oe_n}, 32'h0);
        wait_flag;
        chk({31'h0, xfer_irq_flag}, 32'h1);
        apb(1'b0, `ADDR_BUFFER, 16'h0000);
        apb(1'b1, `ADDR_IRQ, 16'h0000);
        // Frame slave: a held sync input starts words with no new write
        ss_b <= 1'b1;
        apb(1'b1, `ADDR_CONTROL, 16'h603E);
        wait_flag;
        chk({31'h0, ss_oe_n}, 32'h1);
        chk({31'h0, xfer_irq_flag}, 32'h1);
        apb(1'b1, `ADDR_CONTROL, 16'h0000);
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
